// ==== src/pma_pmd_mmd_ctrl_status_regs.sv ====
/*
 PMA/PMD management register set: control, status, devices in
 package and type select, with soft reset sequencing, strap-driven
 power-down default, latch-low link status and local loopback.
 Assumes an outside frame engine that hands over one access at a
 time as a mgmt_req_t pulse, and answers reads for its own devad.
*/
`timescale 1ns/100ps

// Notes on behaviour
// - decode device address 0x01, registers 0x0000, 0x0001, 0x0005-0x0007
// - writing 1 to control one bit 15 reinitializes the device
// - soft reset bit self-clears; reads 1 only while reset runs
// - control one bit 11 puts the device in low-power mode
// - register access keeps working during power-down
// - power-down reset value follows the strap pin
// - loopback bit set: transmit data returned on receive path
// - loopback bit clear: normal receive path
// - status one bit 2 is link up, latched low until read
// - status one bit 1 always reads 1; reset value 0x0002
// - devices low word reads constant 0x8B
// - devices high word reads constant 0xC000
// - type select bits 6:0 act only in forced mode without autoneg
// - with autoneg enabled, type comes from autoneg result
// - type select resets to 0x3D; software can write any 7-bit code into it
// - control one reset value depends on the strap pin
module pma_pmd_mmd_ctrl_status_regs
   import pma_regs_pkg::*;
#(
   parameter int SYMBOL_WIDTH      = 4,
   parameter int RESET_HOLD_CYCLES = pma_regs_pkg::SOFT_RESET_CYCLES
) (
   // clock and reset
   input  wire logic                    clock,
   input  wire logic                    resetn,
   // management access
   input  pma_regs_pkg::mgmt_req_t      mgmt_req,
   output pma_regs_pkg::mgmt_rsp_t      mgmt_rsp,
   // strap
   input  wire logic                    power_down_strap_pin,
   // link and negotiation state
   input  wire logic                    link_up,
   input  wire logic                    autoneg_enable,
   input  wire logic                    forced_link_enable,
   input  wire logic [6:0]              autoneg_phy_type,
   // datapath
   input  wire logic [SYMBOL_WIDTH-1:0] tx_symbol,
   input  wire logic [SYMBOL_WIDTH-1:0] line_rx_symbol,
   output logic      [SYMBOL_WIDTH-1:0] rx_symbol,
   // device control
   output logic                         chip_reset_n,
   output logic                         soft_power_down_bit,
   output logic                         local_loopback_enable,
   output logic      [6:0]              active_phy_type
);
   import pma_regs_pkg::*;

   localparam int CNT_W = (RESET_HOLD_CYCLES > 1) ?
                          $clog2(RESET_HOLD_CYCLES) : 1;

   typedef struct packed {
      reset_seq_t        seq;
      logic [CNT_W-1:0]  count;
      logic              strap_taken;
      logic              strap_value;
      logic              power_down;
      logic              loopback;
      logic [6:0]        type_select;
      logic [6:0]        active_type;
      logic              chip_reset_n;
      mgmt_rsp_t         rsp;
   } state_t;

   localparam state_t STATE_RESET = '{
      seq:          SEQ_IDLE,
      count:        '0,
      strap_taken:  1'b0,
      strap_value:  1'b0,
      power_down:   CONTROL_ONE_RESET[POWER_DOWN_BIT],
      loopback:     CONTROL_ONE_RESET[LOOPBACK_BIT],
      type_select:  TYPE_SELECT_RESET,
      active_type:  TYPE_SELECT_RESET,
      chip_reset_n: 1'b1,
      rsp:          '0
   };

   state_t s_r;
   state_t s_nxt;

   logic link_latched;
   logic status_read;
   logic soft_active;

   // access to one register of this device
   function automatic logic hits(input mgmt_req_t req,
                                 input logic [15:0] addr);
      hits = req.valid && (req.devad == PMA_DEVAD)
             && (req.regad == addr);
   endfunction

   // read word for a register address, zero when unmapped
   function automatic logic [15:0] read_word(input logic [15:0] addr,
                                             input state_t st,
                                             input logic link_bit,
                                             input logic in_reset);
      logic [15:0] w;
      w = '0;
      if (addr == ADDR_CONTROL_ONE) begin
         w[SOFT_RESET_BIT] = in_reset;
         w[POWER_DOWN_BIT] = st.power_down;
         w[LOOPBACK_BIT]   = st.loopback;
      end else if (addr == ADDR_STATUS_ONE) begin
         w = STATUS_ONE_RESET;
         w[LINK_UP_BIT] = link_bit;
      end else if (addr == ADDR_DEVICES_LOW) begin
         w = DEVICES_LOW_VALUE;
      end else if (addr == ADDR_DEVICES_HIGH) begin
         w = DEVICES_HIGH_VALUE;
      end else if (addr == ADDR_CONTROL_TWO) begin
         w[TYPE_SELECT_WIDTH-1:0] = st.type_select;
      end
      read_word = w;
   endfunction

   assign soft_active = (s_r.seq == SEQ_RESET);
   assign status_read = hits(mgmt_req, ADDR_STATUS_ONE)
                        && !mgmt_req.write;

   always_comb begin
      s_nxt = s_r;
      s_nxt.rsp.valid = 1'b0;
      s_nxt.rsp.rdata = '0;

      // strap sampled on the first edge after reset release
      if (!s_r.strap_taken) begin
         s_nxt.strap_taken = 1'b1;
         s_nxt.strap_value = power_down_strap_pin;
         s_nxt.power_down  = power_down_strap_pin;
      end

      case (s_r.seq)
         SEQ_IDLE: begin
            if (hits(mgmt_req, ADDR_CONTROL_ONE) && mgmt_req.write) begin
               if (mgmt_req.wdata[SOFT_RESET_BIT]) begin
                  s_nxt.seq          = SEQ_RESET;
                  s_nxt.count        = CNT_W'(RESET_HOLD_CYCLES - 1);
                  s_nxt.chip_reset_n = 1'b0;
               end else begin
                  s_nxt.power_down = mgmt_req.wdata[POWER_DOWN_BIT];
                  s_nxt.loopback   = mgmt_req.wdata[LOOPBACK_BIT];
               end
            end
            if (hits(mgmt_req, ADDR_CONTROL_TWO) && mgmt_req.write) begin
               s_nxt.type_select =
                  mgmt_req.wdata[TYPE_SELECT_WIDTH-1:0];
            end
         end
         SEQ_RESET: begin
            // writes are dropped while the device reinitializes
            if (s_r.count == '0) begin
               s_nxt.seq          = SEQ_IDLE;
               s_nxt.chip_reset_n = 1'b1;
               s_nxt.power_down   = s_r.strap_value;
               s_nxt.loopback     = CONTROL_ONE_RESET[LOOPBACK_BIT];
               s_nxt.type_select  = TYPE_SELECT_RESET;
            end else begin
               s_nxt.count = s_r.count - CNT_W'(1);
            end
         end
         default: begin
            s_nxt.seq = SEQ_IDLE;
         end
      endcase

      // reads answered in every state, power-down included
      if (mgmt_req.valid && !mgmt_req.write
          && (mgmt_req.devad == PMA_DEVAD)) begin
         s_nxt.rsp.valid = 1'b1;
         s_nxt.rsp.rdata = read_word(mgmt_req.regad, s_r,
                                     link_latched, soft_active);
      end

      // type in use follows autoneg when enabled, else type select when forced, else 0x3D
      if (autoneg_enable) begin
         s_nxt.active_type = autoneg_phy_type;
      end else if (forced_link_enable) begin
         s_nxt.active_type = s_r.type_select;
      end else begin
         s_nxt.active_type = TYPE_SELECT_RESET;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         s_r <= STATE_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   link_latch_low u_link (
      .clock        (clock),
      .resetn       (resetn),
      .clear        (soft_active),
      .read_strobe  (status_read),
      .link_up      (link_up),
      .link_latched (link_latched)
   );

   pma_loopback #(
      .WIDTH (SYMBOL_WIDTH)
   ) u_loop (
      .clock           (clock),
      .resetn          (resetn),
      .loopback_enable (s_r.loopback),
      .tx_symbol       (tx_symbol),
      .line_rx_symbol  (line_rx_symbol),
      .rx_symbol       (rx_symbol)
   );

   assign mgmt_rsp              = s_r.rsp;
   assign chip_reset_n          = s_r.chip_reset_n;
   assign soft_power_down_bit   = s_r.power_down;
   assign local_loopback_enable = s_r.loopback;
   assign active_phy_type       = s_r.active_type;
endmodule

// ==== src/pma_regs_pkg.sv ====
/*
 Constants, field positions and carrier types for the PMA/PMD
 management register set.
 Assumes an outside frame engine that delivers one decoded access
 per request.
*/
package pma_regs_pkg;

   // management device and register addresses
   localparam logic [4:0]  PMA_DEVAD          = 5'h01;
   localparam logic [15:0] ADDR_CONTROL_ONE   = 16'h0000;
   localparam logic [15:0] ADDR_STATUS_ONE    = 16'h0001;
   localparam logic [15:0] ADDR_DEVICES_LOW   = 16'h0005;
   localparam logic [15:0] ADDR_DEVICES_HIGH  = 16'h0006;
   localparam logic [15:0] ADDR_CONTROL_TWO   = 16'h0007;

   // field positions
   localparam int SOFT_RESET_BIT     = 15;
   localparam int POWER_DOWN_BIT     = 11;
   localparam int LOOPBACK_BIT       = 0;
   localparam int LINK_UP_BIT        = 2;
   localparam int PD_CAPABLE_BIT     = 1;
   localparam int TYPE_SELECT_WIDTH  = 7;

   // reset and constant values
   localparam logic [15:0] CONTROL_ONE_RESET  = 16'h0000;
   localparam logic [15:0] STATUS_ONE_RESET   = 16'h0002;
   localparam logic [15:0] DEVICES_LOW_VALUE  = 16'h008B;
   localparam logic [15:0] DEVICES_HIGH_VALUE = 16'hC000;
   localparam logic [6:0]  TYPE_SELECT_RESET  = 7'h3D;

   // soft reset duration
   localparam int CLOCK_PERIOD_NS    = 5;
   localparam int SOFT_RESET_TIME_NS = 100;
   localparam int SOFT_RESET_CYCLES  =
      (SOFT_RESET_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

   typedef enum logic [1:0] {
      SEQ_IDLE  = 2'b01,
      SEQ_RESET = 2'b10
   } reset_seq_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [4:0]  devad;
      logic [15:0] regad;
      logic [15:0] wdata;
   } mgmt_req_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] rdata;
   } mgmt_rsp_t;

endpackage

// ==== src/link_latch_low.sv ====
/*
 Latch-low link status flag.
 Assumes link_up and read_strobe are synchronous to clock.
*/
`timescale 1ns/100ps
module link_latch_low (
   // clock and reset
   input  wire logic clock,
   input  wire logic resetn,
   // control
   input  wire logic clear,
   input  wire logic read_strobe,
   // status
   input  wire logic link_up,
   output logic      link_latched
);
   typedef struct packed {
      logic latched;
   } latch_state_t;

   latch_state_t s_r;
   latch_state_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      // a drop in the read cycle still wins
      if (clear) begin
         s_nxt.latched = 1'b0;
      end else if (read_strobe) begin
         s_nxt.latched = link_up;
      end else begin
         s_nxt.latched = s_r.latched & link_up;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign link_latched = s_r.latched;
endmodule

// ==== src/pma_loopback.sv ====
/*
 Receive path selector of the PMA: line data or looped transmit data.
 Assumes symbols are synchronous to clock.
*/
`timescale 1ns/100ps
module pma_loopback #(
   parameter int WIDTH = 4
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             resetn,
   // mode
   input  wire logic             loopback_enable,
   // data
   input  wire logic [WIDTH-1:0] tx_symbol,
   input  wire logic [WIDTH-1:0] line_rx_symbol,
   output logic      [WIDTH-1:0] rx_symbol
);
   typedef struct packed {
      logic [WIDTH-1:0] rx;
   } loop_state_t;

   loop_state_t s_r;
   loop_state_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (loopback_enable) begin
         s_nxt.rx = tx_symbol;
      end else begin
         s_nxt.rx = line_rx_symbol;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rx_symbol = s_r.rx;
endmodule

// ==== verification/pma_regs_asserts.sv ====
/* checker on the ports of the pma register set
   bound from tb_top; sees the top module ports only */
`timescale 1ns/100ps
module pma_regs_asserts
   import pma_regs_pkg::*;
#(parameter int SYMBOL_WIDTH = 4) (
   // clock and reset
   input wire logic                    clock,
   input wire logic                    resetn,
   // access
   input pma_regs_pkg::mgmt_req_t      mgmt_req,
   input pma_regs_pkg::mgmt_rsp_t      mgmt_rsp,
   // levels
   input wire logic                    power_down_strap_pin,
   input wire logic                    link_up,
   input wire logic                    autoneg_enable,
   input wire logic                    forced_link_enable,
   input wire logic [6:0]              autoneg_phy_type,
   // datapath
   input wire logic [SYMBOL_WIDTH-1:0] tx_symbol,
   input wire logic [SYMBOL_WIDTH-1:0] line_rx_symbol,
   input wire logic [SYMBOL_WIDTH-1:0] rx_symbol,
   // device control
   input wire logic                    chip_reset_n,
   input wire logic                    soft_power_down_bit,
   input wire logic                    local_loopback_enable,
   input wire logic [6:0]              active_phy_type
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   wire own = mgmt_req.valid && mgmt_req.devad == 5'h01;
   wire rd  = own && !mgmt_req.write;
   wire wr0 = own && mgmt_req.write && mgmt_req.regad == 16'h0000;

   a_read_answer: assert property (
      rd |=> mgmt_rsp.valid) else $error("read not answered");
   a_foreign_dev: assert property (
      mgmt_req.valid && mgmt_req.devad != 5'h01 |=> !mgmt_rsp.valid)
      else $error("foreign device answered");
   a_devs_low: assert property (
      rd && mgmt_req.regad == 16'h0005 |=> mgmt_rsp.rdata == 16'h008B)
      else $error("devices low word wrong");
   a_status_fixed: assert property (
      rd && mgmt_req.regad == 16'h0001 |=> mgmt_rsp.rdata[1]
      && mgmt_rsp.rdata[15:3] == 13'h0 && !mgmt_rsp.rdata[0])
      else $error("status fixed bits wrong");
   a_loop_path: assert property (
      $past(resetn) |-> rx_symbol == ($past(local_loopback_enable)
      ? $past(tx_symbol) : $past(line_rx_symbol)))
      else $error("receive path wrong");
   a_auto_type: assert property (
      autoneg_enable |=> active_phy_type == $past(autoneg_phy_type))
      else $error("autoneg type not used");
   a_reset_cause: assert property (
      $fell(chip_reset_n) |-> $past(wr0 && mgmt_req.wdata[15]))
      else $error("soft reset without request");
   a_reset_ends: assert property (
      $fell(chip_reset_n) |-> ##[1:40] chip_reset_n)
      else $error("soft reset never ends");
   a_ctrl_write: assert property (
      wr0 && !mgmt_req.wdata[15] && chip_reset_n |=>
      soft_power_down_bit == $past(mgmt_req.wdata[11])
      && local_loopback_enable == $past(mgmt_req.wdata[0]))
      else $error("control write not applied");

   cover property (wr0 && mgmt_req.wdata[15]);
   cover property (rd ##1 mgmt_rsp.rdata[2]);
   cover property (local_loopback_enable && !link_up);
endmodule

// ==== verification/mgmt_host.sv ====
/* station management host model on the access port
   clock from the bench; changes its request at falling edges */
`timescale 1ns/100ps
module mgmt_host
   import pma_regs_pkg::*;
(
   // clock
   input  wire logic               clock,
   // access port
   output pma_regs_pkg::mgmt_req_t req,
   input  pma_regs_pkg::mgmt_rsp_t rsp
);
   initial req = '0;
   // one access; a read waits a bounded time for its answer
   task automatic acc(input logic w, input logic [4:0] dv,
      input logic [15:0] ra, wd, output logic [15:0] rdat,
      output logic got);
      got = w;
      rdat = 16'h0000;
      @(negedge clock);
      req <= '{1'b1, w, dv, ra, wd};
      @(negedge clock);
      req <= '{1'b0, 1'b0, ~dv, ~ra, ~wd};
      for (int i = 0; i < 3 && !got; i++) begin
         if (rsp.valid === 1'b1) begin
            got = 1'b1;
            rdat = rsp.rdata;
         end
         else @(negedge clock);
      end
   endtask
endmodule

// ==== verification/tb_top.sv ====
/* self-checking bench for the pma register set
   host model drives access; checker bound below; 200 MHz */
`timescale 1ns/100ps
module tb_top;
   import pma_regs_pkg::*;
   logic        clock = 0, resetn = 0, strap = 1, link_up = 1;
   logic        an = 0, fl = 0, crn, pd, lb, got;
   logic [6:0]  an_type = 7'h12, act;
   logic [3:0]  tx = 4'hA, line = 4'h5, rx;
   logic [15:0] rdat;
   mgmt_req_t   req;
   mgmt_rsp_t   rsp;
   int          n_mismatch = 0, samples_checked = 0;

   always #2.5 clock = ~clock;
   mgmt_host h (.clock, .req, .rsp);
   pma_pmd_mmd_ctrl_status_regs #(.RESET_HOLD_CYCLES(6)) uut (
      .clock, .resetn, .mgmt_req(req), .mgmt_rsp(rsp),
      .power_down_strap_pin(strap), .link_up, .autoneg_enable(an),
      .forced_link_enable(fl), .autoneg_phy_type(an_type),
      .tx_symbol(tx), .line_rx_symbol(line), .rx_symbol(rx),
      .chip_reset_n(crn), .soft_power_down_bit(pd),
      .local_loopback_enable(lb), .active_phy_type(act));

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [15:0] ra, wd);
      h.acc(1'b1, 5'h01, ra, wd, rdat, got);
   endtask
   task automatic rd(input logic [15:0] ra, exp);
      h.acc(1'b0, 5'h01, ra, 16'h0000, rdat, got);
      if (got !== 1'b1) begin
         n_mismatch++;
         end_of_test;
      end else begin
         chk("rdata", rdat, exp);
      end
   endtask

   task automatic t_reset_values;
      rd(16'h0000, 16'h0800);
      rd(16'h0001, 16'h0002);
      rd(16'h0001, 16'h0006);
      rd(16'h0005, 16'h008B);
      rd(16'h0006, 16'hC000);
      rd(16'h0007, 16'h003D);
      rd(16'h0002, 16'h0000);
      h.acc(1'b0, 5'h02, 16'h0000, 16'h0000, rdat, got);
      chk("foreign", {15'h0, got}, 16'h0000);
      chk("pd_port", {15'h0, pd}, 16'h0001);
   endtask
   task automatic t_power_down;
      wr(16'h0000, 16'h7FFF);
      rd(16'h0000, 16'h0801);
      chk("lb_port", {15'h0, lb}, 16'h0001);
      wr(16'h0001, 16'hFFFF);
      rd(16'h0001, 16'h0006);
      wr(16'h0000, 16'h0000);
      rd(16'h0000, 16'h0000);
      chk("pd_port", {15'h0, pd}, 16'h0000);
   endtask
   task automatic t_loopback;
      wr(16'h0000, 16'h0001);
      @(negedge clock);
      tx = 4'h3;
      line = 4'hC;
      @(negedge clock);
      chk("rx_loop", {12'h0, rx}, 16'h0003);
      wr(16'h0000, 16'h0000);
      @(negedge clock);
      chk("rx_line", {12'h0, rx}, 16'h000C);
   endtask
   task automatic t_link_drop;
      @(negedge clock);
      link_up = 0;
      @(negedge clock);
      link_up = 1;
      rd(16'h0001, 16'h0002);
      rd(16'h0001, 16'h0006);
   endtask
   task automatic t_type;
      wr(16'h0007, 16'hFFBD);
      rd(16'h0007, 16'h003D);
      an = 1;
      @(negedge clock);
      chk("type_an", {9'h0, act}, 16'h0012);
      an = 0;
      fl = 1;
      @(negedge clock);
      chk("type_forced", {9'h0, act}, 16'h003D);
      an = 1;
      @(negedge clock);
      chk("type_both", {9'h0, act}, 16'h0012);
      an = 0;
      fl = 0;
      @(negedge clock);
      chk("type_none", {9'h0, act}, 16'h003D);
   endtask
   task automatic t_soft_reset;
      wr(16'h0000, 16'h0001);
      wr(16'h0000, 16'h8000);
      chk("crn", {15'h0, crn}, 16'h0000);
      rd(16'h0000, 16'h8001);
      for (int i = 0; i < 50 && crn !== 1'b1; i++) @(negedge clock);
      if (crn !== 1'b1) begin
         n_mismatch++;
         end_of_test;
      end else begin
         chk("crn_end", {15'h0, crn}, 16'h0001);
      end
      rd(16'h0000, 16'h0800);
      chk("lb_reinit", {15'h0, lb}, 16'h0000);
      rd(16'h0001, 16'h0002);
   endtask
   task automatic t_strap;
      @(negedge clock);
      resetn = 0;
      strap = 0;
      repeat (10) @(negedge clock);
      resetn = 1;
      repeat (3) @(negedge clock);
      rd(16'h0000, 16'h0000);
      chk("pd_strap", {15'h0, pd}, 16'h0000);
      rd(16'h0001, 16'h0002);
   endtask

   initial begin
      repeat (10) @(negedge clock);
      resetn = 1;
      repeat (3) @(negedge clock);
      t_reset_values;
      t_power_down;
      t_loopback;
      t_link_drop;
      t_type;
      t_soft_reset;
      t_strap;
      end_of_test;
   end
endmodule

bind pma_pmd_mmd_ctrl_status_regs pma_regs_asserts #(
   .SYMBOL_WIDTH(SYMBOL_WIDTH)) chk_i (.clock, .resetn, .mgmt_req,
   .mgmt_rsp, .power_down_strap_pin, .link_up, .autoneg_enable,
   .forced_link_enable, .autoneg_phy_type, .tx_symbol, .line_rx_symbol,
   .rx_symbol, .chip_reset_n, .soft_power_down_bit,
   .local_loopback_enable, .active_phy_type);
